// >>> rtl/flag_pin_mux.v
`timescale 1ns/1ps
`include "pport_map.vh"
// routing of the four general flag pins
module flag_pin_mux
(
  // clock and reset
  input  wire        i_sys_clk,
  input  wire        i_nrst,
  // configuration
  input  wire [31:0] i_system_control_reg,
  input  wire [3:0]  i_flag_dir_out,
  input  wire [3:0]  i_flag_out_val,
  input  wire [3:0]  i_spi_sel_en,
  input  wire [3:0]  i_spi_sel_val,
  input  wire        i_spi_master,
  input  wire        i_spi_master_boot,
  input  wire        i_sys_timer_expired,
  // synchronised pin levels
  input  wire [3:0]  i_flag_sync,
  // results
  output reg  [3:0]  o_flag_out,
  output reg  [3:0]  o_flag_oe_n,
  output reg  [3:0]  o_flag_cond,
  output reg  [2:0]  o_ext_irq_in
);
  wire [2:0] irq_sel;
  assign irq_sel = {i_system_control_reg[`CTL_IRQ_IN2_BIT],
                    i_system_control_reg[`CTL_IRQ_IN1_BIT],
                    i_system_control_reg[`CTL_IRQ_IN0_BIT]};

  reg [3:0] out_next;
  reg [3:0] oe_n_next;
  reg [2:0] irq_next;
  integer k;

  always @*
  begin
    out_next  = 4'h0;
    oe_n_next = 4'hf;
    irq_next  = 3'h0;
    for (k = 0; k < 4; k = k + 1)
    begin
      if (i_spi_master_boot && k == 0)
      begin
        out_next[0]  = i_spi_sel_val[0];
        oe_n_next[0] = 1'b0;
      end
      else if (k < 3 && irq_sel[k])
      begin
        irq_next[k] = i_flag_sync[k];
      end
      else if (k == 3 && i_system_control_reg[`CTL_TIMER_OUT_BIT])
      begin
        out_next[3]  = i_sys_timer_expired;
        oe_n_next[3] = 1'b0;
      end
      else if (i_spi_master && i_spi_sel_en[k])
      begin
        out_next[k]  = i_spi_sel_val[k];
        oe_n_next[k] = 1'b0;
      end
      else if (i_flag_dir_out[k])
      begin
        out_next[k]  = i_flag_out_val[k];
        oe_n_next[k] = 1'b0;
      end
    end
  end

  always @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_flag_out   <= 4'h0;
      o_flag_oe_n  <= 4'hf;
      o_flag_cond  <= 4'h0;
      o_ext_irq_in <= 3'h0;
    end
    else
    begin
      o_flag_out   <= out_next;
      o_flag_oe_n  <= oe_n_next;
      o_flag_cond  <= i_flag_sync;
      o_ext_irq_in <= irq_next;
    end
  end
endmodule

// >>> rtl/parallel_port_flag_pins.v
`timescale 1ns/1ps
`include "pport_map.vh"
module parallel_port_flag_pins
(
  // clock and reset
  input  wire                 i_sys_clk,
  input  wire                 i_nrst,
  // configuration
  input  wire [31:0]          i_system_control_reg,
  input  wire                 i_port_enable,
  input  wire                 i_mode_16bit,
  input  wire                 i_ale_active_low,
  input  wire                 i_pdap_enable,
  // access request from the port engine
  input  wire                 i_req_valid,
  input  wire                 i_req_write,
  input  wire [`ADDR_W-1:0]   i_req_addr,
  input  wire [`DATA_W-1:0]   i_req_wdata,
  output reg                  o_req_ready,
  output reg                  o_rdata_valid,
  output reg  [`DATA_W-1:0]   o_rdata,
  // shared address/data pins
  input  wire [`DATA_W-1:0]   i_shared_addr_data_pins,
  output reg  [`DATA_W-1:0]   o_shared_addr_data_pins,
  output reg  [`DATA_W-1:0]   o_shared_addr_data_oe_n,
  output reg                  o_rd_n,
  output reg                  o_wr_n,
  output reg                  o_ale,
  // bus flag mode
  input  wire [`DATA_W-1:0]   i_bus_flag_dir_out,
  input  wire [`DATA_W-1:0]   i_bus_flag_out_val,
  output reg  [`DATA_W-1:0]   o_bus_flag_pins,
  // input data port channel 0
  output reg  [`DATA_W-1:0]   o_input_data_port_data,
  output reg                  o_input_data_port_valid,
  // general flag pins
  input  wire [3:0]           i_general_flag_pins,
  input  wire [3:0]           i_flag_dir_out,
  input  wire [3:0]           i_flag_out_val,
  input  wire                 i_spi_master,
  input  wire                 i_spi_master_boot,
  input  wire [3:0]           i_spi_sel_en,
  input  wire [3:0]           i_spi_sel_val,
  input  wire                 i_sys_timer_expired,
  output wire [3:0]           o_general_flag_pins,
  output wire [3:0]           o_general_flag_oe_n,
  output wire [3:0]           o_flag_cond,
  output wire [2:0]           o_ext_irq_in
);
  wire [`DATA_W-1:0] ad_sync;
  wire [3:0]         flag_sync;

  pin_sync #(.W(`DATA_W)) u_ad_sync (
    .i_sys_clk (i_sys_clk),
    .i_nrst    (i_nrst),
    .i_async   (i_shared_addr_data_pins),
    .o_sync    (ad_sync)
  );

  pin_sync #(.W(4)) u_flag_sync (
    .i_sys_clk (i_sys_clk),
    .i_nrst    (i_nrst),
    .i_async   (i_general_flag_pins),
    .o_sync    (flag_sync)
  );

  flag_pin_mux u_flags (
    .i_sys_clk           (i_sys_clk),
    .i_nrst              (i_nrst),
    .i_system_control_reg(i_system_control_reg),
    .i_flag_dir_out      (i_flag_dir_out),
    .i_flag_out_val      (i_flag_out_val),
    .i_spi_sel_en        (i_spi_sel_en),
    .i_spi_sel_val       (i_spi_sel_val),
    .i_spi_master        (i_spi_master),
    .i_spi_master_boot   (i_spi_master_boot),
    .i_sys_timer_expired (i_sys_timer_expired),
    .i_flag_sync         (flag_sync),
    .o_flag_out          (o_general_flag_pins),
    .o_flag_oe_n         (o_general_flag_oe_n),
    .o_flag_cond         (o_flag_cond),
    .o_ext_irq_in        (o_ext_irq_in)
  );

  // mode decode
  wire flag_mode;
  wire pdap_mode;
  assign flag_mode = !i_port_enable &&
                     i_system_control_reg[`CTL_BUSFLAG_BIT];
  assign pdap_mode = !i_port_enable && !flag_mode && i_pdap_enable;

  // the tracked address portion: upper in 8-bit, lower in 16-bit
  function [15:0] tag_of;
    input [`ADDR_W-1:0] a;
    input               m16;
    begin
      if (m16)
        tag_of = a[15:0];
      else
        tag_of = a[23:8];
    end
  endfunction

  // access sequencer states
  localparam [2:0] ST_IDLE   = 3'h0;
  localparam [2:0] ST_ALE    = 3'h1;
  localparam [2:0] ST_HOLD   = 3'h2;
  localparam [2:0] ST_STROBE = 3'h3;
  localparam [2:0] ST_END    = 3'h4;

  reg  [2:0]         state_reg;
  reg  [2:0]         state_next;
  reg  [3:0]         cnt_reg;
  reg  [3:0]         cnt_next;
  reg  [15:0]        last_tag_reg;
  reg                tag_valid_reg;
  reg                mode16_reg;
  reg                wr_reg;
  reg  [`ADDR_W-1:0] addr_reg;
  reg  [`DATA_W-1:0] wdata_reg;

  wire new_tag;
  assign new_tag = !tag_valid_reg ||
                   tag_of(i_req_addr, i_mode_16bit) != last_tag_reg ||
                   i_mode_16bit != mode16_reg;

  always @*
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    case (state_reg)
      ST_IDLE:
        if (i_req_valid && i_port_enable)
        begin
          state_next = new_tag ? ST_ALE : ST_STROBE;
          cnt_next   = new_tag ? `ALE_CYCLES : `STROBE_CYCLES;
        end
      ST_ALE:
        if (cnt_reg == 4'h1)
        begin
          state_next = ST_HOLD;
          cnt_next   = `HOLD_CYCLES;
        end
        else
          cnt_next = cnt_reg - 4'h1;
      ST_HOLD:
        if (cnt_reg == 4'h1)
        begin
          state_next = ST_STROBE;
          cnt_next   = `STROBE_CYCLES;
        end
        else
          cnt_next = cnt_reg - 4'h1;
      ST_STROBE:
        if (cnt_reg == 4'h1)
          state_next = ST_END;
        else
          cnt_next = cnt_reg - 4'h1;
      ST_END:
        state_next = ST_IDLE;
      default:
        state_next = ST_IDLE;
    endcase
  end

  always @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      state_reg     <= ST_IDLE;
      cnt_reg       <= 4'h0;
      last_tag_reg  <= 16'h0000;
      tag_valid_reg <= 1'b0;
      mode16_reg    <= 1'b0;
      wr_reg        <= 1'b0;
      addr_reg      <= 24'h000000;
      wdata_reg     <= 16'h0000;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      if (state_reg == ST_IDLE && i_req_valid && i_port_enable)
      begin
        wr_reg        <= i_req_write;
        addr_reg      <= i_req_addr;
        wdata_reg     <= i_req_wdata;
        mode16_reg    <= i_mode_16bit;
        last_tag_reg  <= tag_of(i_req_addr, i_mode_16bit);
        tag_valid_reg <= 1'b1;
      end
      else if (!i_port_enable)
        tag_valid_reg <= 1'b0; // relatch after re-enable, latch may be stale
    end
  end

  // registered pin drive
  reg [`DATA_W-1:0] ad_next;
  reg [`DATA_W-1:0] oe_next;
  reg               ale_on;
  reg               rd_on;
  reg               wr_on;

  always @*
  begin
    ad_next = 16'h0000;
    oe_next = 16'h0000;
    ale_on  = 1'b0;
    rd_on   = 1'b0;
    wr_on   = 1'b0;
    if (flag_mode)
    begin
      ad_next = i_bus_flag_out_val & i_bus_flag_dir_out;
      oe_next = ~i_bus_flag_dir_out;
    end
    else if (pdap_mode)
      oe_next = 16'hffff;
    else
    begin
      case (state_next)
        ST_ALE:
        begin
          ale_on = 1'b1;
          // mode is frozen once the access is taken
          if ((state_reg == ST_IDLE) ? i_mode_16bit : mode16_reg)
            ad_next = (state_reg == ST_IDLE) ? i_req_addr[15:0]
                                             : addr_reg[15:0];
          else
            ad_next = (state_reg == ST_IDLE) ? i_req_addr[23:8]
                                             : addr_reg[23:8];
        end
        ST_HOLD:
          ad_next = mode16_reg ? addr_reg[15:0] : addr_reg[23:8];
        ST_STROBE:
        begin
          if ((state_reg == ST_IDLE) ? i_req_write : wr_reg)
          begin
            wr_on   = 1'b1;
            ad_next = (state_reg == ST_IDLE) ? i_req_wdata : wdata_reg;
            if (!((state_reg == ST_IDLE) ? i_mode_16bit : mode16_reg))
              ad_next[15:8] = 8'h00;
          end
          else
          begin
            rd_on   = 1'b1;
            oe_next = 16'hffff;
          end
        end
        default:
          ad_next = 16'h0000;
      endcase
    end
  end

  always @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_shared_addr_data_pins <= 16'h0000;
      o_shared_addr_data_oe_n <= 16'h0000;
      o_rd_n                  <= 1'b1;
      o_wr_n                  <= 1'b1;
      o_ale                   <= 1'b0;
      o_req_ready             <= 1'b0;
      o_rdata_valid           <= 1'b0;
      o_rdata                 <= 16'h0000;
      o_bus_flag_pins         <= 16'h0000;
      o_input_data_port_data  <= 16'h0000;
      o_input_data_port_valid <= 1'b0;
    end
    else
    begin
      o_shared_addr_data_pins <= ad_next;
      o_shared_addr_data_oe_n <= oe_next;
      o_rd_n  <= !rd_on;
      o_wr_n  <= !wr_on;
      o_ale   <= ale_on ^ i_ale_active_low;
      o_req_ready   <= state_next == ST_IDLE && i_port_enable;
      o_rdata_valid <= state_reg == ST_STROBE && cnt_reg == 4'h1 &&
                       !wr_reg;
      if (state_reg == ST_STROBE && cnt_reg == 4'h1 && !wr_reg)
        o_rdata <= mode16_reg ? ad_sync : {8'h00, ad_sync[7:0]};
      o_bus_flag_pins         <= flag_mode ? ad_sync : 16'h0000;
      o_input_data_port_data  <= pdap_mode ? ad_sync : 16'h0000;
      o_input_data_port_valid <= pdap_mode;
    end
  end
endmodule

// >>> rtl/pin_sync.v
`timescale 1ns/1ps
`include "pport_map.vh"
// two-flop synchroniser for a vector of pin inputs
module pin_sync #(
  parameter W = 4
)
(
  // clock and reset
  input  wire         i_sys_clk,
  input  wire         i_nrst,
  // data
  input  wire [W-1:0] i_async,
  output wire [W-1:0] o_sync
);
  reg [W-1:0] meta_reg;
  reg [W-1:0] sync_reg;

  always @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      meta_reg <= {W{1'b0}};
      sync_reg <= {W{1'b0}};
    end
    else
    begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
    end
  end

  assign o_sync = sync_reg;
endmodule

// >>> rtl/pport_map.vh
`ifndef PPORT_MAP_VH
`define PPORT_MAP_VH

// system control bit positions
`define CTL_IRQ_IN0_BIT    16
`define CTL_IRQ_IN1_BIT    17
`define CTL_IRQ_IN2_BIT    18
`define CTL_TIMER_OUT_BIT  19
`define CTL_BUSFLAG_BIT    20

// cycle counts of each access phase
`define ALE_CYCLES    4'h2
`define HOLD_CYCLES   4'h1
`define STROBE_CYCLES 4'h4

// widths
`define ADDR_W 24
`define DATA_W 16

`endif

// >>> verif/parallel_port_flag_pins_asserts.sv
`timescale 1ns/1ps
module pport_checker
(
  // clock and reset
  input wire        i_sys_clk,
  input wire        i_nrst,
  // configuration and request
  input wire [31:0] i_system_control_reg,
  input wire        i_port_enable,
  input wire        i_ale_active_low,
  input wire        i_spi_master_boot,
  input wire        i_req_valid,
  // watched outputs
  input wire        o_req_ready,
  input wire        o_rdata_valid,
  input wire [15:0] o_shared_addr_data_pins,
  input wire [15:0] o_shared_addr_data_oe_n,
  input wire        o_rd_n,
  input wire        o_wr_n,
  input wire        o_ale,
  input wire [3:0]  o_general_flag_oe_n,
  input wire [2:0]  o_ext_irq_in
);
  wire ale_on = o_ale ^ i_ale_active_low;
  wire flag_mode = !i_port_enable && i_system_control_reg[20];
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_nrst);
  a_reset_pins: assert property (disable iff (1'b0) !i_nrst |->
    o_rd_n && o_wr_n && !o_ale && o_shared_addr_data_pins == 16'h0000
    && o_shared_addr_data_oe_n == 16'h0000) else $error("reset levels");
  a_one_strobe: assert property (o_rd_n || o_wr_n)
    else $error("both strobes low");
  a_latch_first: assert property
    ($fell(o_rd_n) || $fell(o_wr_n) |-> !ale_on)
    else $error("latch strobe overlaps read or write");
  a_write_len: assert property
    ($fell(o_wr_n) |-> !o_wr_n [*4] ##1 o_wr_n)
    else $error("write strobe length");
  a_read_len: assert property
    ($fell(o_rd_n) |-> !o_rd_n [*4] ##1 o_rd_n)
    else $error("read strobe length");
  a_read_data: assert property
    ($rose(o_rd_n) |-> o_rdata_valid ##1 !o_rdata_valid)
    else $error("read data pulse");
  a_take_start: assert property
    (o_req_ready && i_req_valid && i_port_enable
    |=> !o_req_ready ##[0:1] (ale_on || !o_rd_n || !o_wr_n))
    else $error("access did not start");
  a_flag_quiet: assert property
    (flag_mode [*8] |-> o_rd_n && o_wr_n && !ale_on)
    else $error("strobe in flag mode");
  a_irq_off: assert property
    (!i_system_control_reg[16] [*2] |-> !o_ext_irq_in[0])
    else $error("interrupt input not routed off");
  a_timer_pin: assert property (i_system_control_reg[19] [*2]
    |-> !o_general_flag_oe_n[3]) else $error("timer pin not driven");
  a_boot_sel: assert property (i_spi_master_boot [*2]
    |-> !o_general_flag_oe_n[0]) else $error("boot select not driven");
  c_write: cover property ($fell(o_wr_n));
  c_read: cover property (o_rdata_valid);
  c_flag: cover property (flag_mode [*8]);
endmodule

bind parallel_port_flag_pins pport_checker chk (
  .i_sys_clk(i_sys_clk), .i_nrst(i_nrst),
  .i_system_control_reg(i_system_control_reg),
  .i_port_enable(i_port_enable), .i_ale_active_low(i_ale_active_low),
  .i_spi_master_boot(i_spi_master_boot), .i_req_valid(i_req_valid),
  .o_req_ready(o_req_ready), .o_rdata_valid(o_rdata_valid),
  .o_shared_addr_data_pins(o_shared_addr_data_pins),
  .o_shared_addr_data_oe_n(o_shared_addr_data_oe_n),
  .o_rd_n(o_rd_n), .o_wr_n(o_wr_n), .o_ale(o_ale),
  .o_general_flag_oe_n(o_general_flag_oe_n), .o_ext_irq_in(o_ext_irq_in));

// >>> verif/parallel_port_flag_pins_tb.sv
`timescale 1ns/1ps
module parallel_port_flag_pins_tb;
  reg         clk = 1'b0;
  reg         nrst = 1'b1;
  reg  [31:0] system_control_reg = 32'h0;
  reg         en = 1'b1;
  reg         m16 = 1'b1;
  reg         pol = 1'b0;
  reg         pdap = 1'b0;
  reg         rv = 1'b0;
  reg         rw = 1'b0;
  reg  [23:0] ra = 24'h0;
  reg  [15:0] wd = 16'h0;
  reg  [15:0] bdir = 16'h0;
  reg  [15:0] bval = 16'h0;
  reg  [3:0]  fext = 4'hd;
  reg  [3:0]  fdir = 4'h0;
  reg  [3:0]  fval = 4'h0;
  reg         spim = 1'b0;
  reg         boot = 1'b0;
  reg  [3:0]  sel_en = 4'h0;
  reg  [3:0]  sel_val = 4'h5;
  reg         tmr = 1'b0;
  reg         xen = 1'b0;
  reg  [15:0] xval = 16'h0;
  wire        ready, rvalid, rd_n, wr_n, ale, acq_v;
  wire [15:0] rdata, ad_out, ad_oe_n, ad_wire, bflag, acq_d, latch;
  wire [3:0]  f_out, f_oe_n, fcond;
  wire [2:0]  irq;
  wire        ale_on = ale ^ pol;
  wire [3:0]  f_wire = (~f_oe_n & f_out) | (f_oe_n & fext);
  integer     n_fail = 0;
  integer     tests_run = 0;
  reg  [15:0] n_ale = 16'h0;
  reg  [15:0] n0;
  reg         ale_q = 1'b0;
  reg  [15:0] rd = 16'h0;

  always #2 clk = ~clk;
  always @(negedge clk)
  begin
    if (nrst && ale_on && !ale_q)
      n_ale = n_ale + 16'h1;
    if (rvalid === 1'b1)
      rd = rdata;
    ale_q = ale_on;
  end

  parallel_port_flag_pins uut (
    .i_sys_clk(clk), .i_nrst(nrst), .i_system_control_reg(system_control_reg),
    .i_port_enable(en), .i_mode_16bit(m16), .i_ale_active_low(pol),
    .i_pdap_enable(pdap), .i_req_valid(rv), .i_req_write(rw),
    .i_req_addr(ra), .i_req_wdata(wd), .o_req_ready(ready),
    .o_rdata_valid(rvalid), .o_rdata(rdata),
    .i_shared_addr_data_pins(ad_wire), .o_shared_addr_data_pins(ad_out),
    .o_shared_addr_data_oe_n(ad_oe_n), .o_rd_n(rd_n), .o_wr_n(wr_n),
    .o_ale(ale), .i_bus_flag_dir_out(bdir), .i_bus_flag_out_val(bval),
    .o_bus_flag_pins(bflag), .o_input_data_port_data(acq_d),
    .o_input_data_port_valid(acq_v), .i_general_flag_pins(f_wire),
    .i_flag_dir_out(fdir), .i_flag_out_val(fval), .i_spi_master(spim),
    .i_spi_master_boot(boot), .i_spi_sel_en(sel_en),
    .i_spi_sel_val(sel_val), .i_sys_timer_expired(tmr),
    .o_general_flag_pins(f_out), .o_general_flag_oe_n(f_oe_n),
    .o_flag_cond(fcond), .o_ext_irq_in(irq));

  pport_mem_model mem (
    .i_sys_clk(clk), .i_ad_out(ad_out), .i_ad_oe_n(ad_oe_n),
    .i_rd_n(rd_n), .i_wr_n(wr_n), .i_ale_on(ale_on), .i_ext_en(xen),
    .i_ext_val(xval), .o_ad_wire(ad_wire), .o_latch(latch));

  task tick(input integer n);
    repeat (n) @(posedge clk) #1;
  endtask

  task check(input [15:0] got, input [15:0] exp, input [8*10-1:0] what);
    begin
      tests_run = tests_run + 1;
      if (got !== exp)
      begin
        n_fail = n_fail + 1;
        $display("unexpected at %0t: %0s got %h", $time, what, got);
      end
    end
  endtask

  // request is held until an edge sees ready, then released
  task access(input w, input [23:0] a, input [15:0] d);
    integer k;
    begin
      rw = w;
      ra = a;
      wd = d;
      rv = 1'b1;
      for (k = 0; k < 40 && ready !== 1'b1; k = k + 1)
        tick(1);
      tick(1);
      rv = 1'b0;
      for (k = 0; k < 40 && ready !== 1'b1; k = k + 1)
        tick(1);
    end
  endtask

  task t_reset;
    begin
      check({rd_n, wr_n, ale}, 3'h6, "strobes");
      check(ad_out | ad_oe_n, 16'h0, "ad low");
    end
  endtask

  task t_bus16;
    begin
      n0 = n_ale;
      access(1'b1, 24'h001235, 16'hbeef);
      check(latch, 16'h1235, "latch16");
      access(1'b0, 24'h001235, 16'h0);
      check(rd, 16'hbeef, "rd16");
      access(1'b1, 24'h001236, 16'h1234);
      check(n_ale - n0, 16'h2, "ale16");
    end
  endtask

  task t_bus8;
    begin
      m16 = 1'b0;
      n0 = n_ale;
      access(1'b1, 24'h0a0b01, 16'h12c5);
      check(latch, 16'h0a0b, "latch8");
      access(1'b0, 24'h0a0b02, 16'h0);
      check(rd, 16'h00c5, "rd8");
      check(n_ale - n0, 16'h1, "ale8");
      access(1'b1, 24'h0a0c02, 16'h0);
      check(n_ale - n0, 16'h2, "ale8b");
    end
  endtask

  task t_pol;
    begin
      pol = 1'b1;
      tick(2);
      check(ale, 1'b1, "ale idle");
      n0 = n_ale;
      access(1'b1, 24'h0a0d00, 16'h0);
      check(n_ale - n0, 16'h1, "ale low");
      check(latch, 16'h0a0d, "latch pol");
      pol = 1'b0;
      tick(2);
    end
  endtask

  task t_flags;
    begin
      en = 1'b0;
      system_control_reg = 32'h00100000;
      bdir = 16'h00ff;
      bval = 16'h5a3c;
      xen = 1'b1;
      xval = 16'h9600;
      rv = 1'b1;
      tick(10);
      check(ad_oe_n, 16'hff00, "flag oe");
      check(ad_out[7:0], 8'h3c, "flag out");
      check(bflag, 16'h963c, "flag in");
      check({rd_n, wr_n, ready}, 3'h6, "quiet");
      rv = 1'b0;
      system_control_reg = 32'h0;
      pdap = 1'b1;
      xval = 16'h1357;
      tick(6);
      check(ad_oe_n, 16'hffff, "idp oe");
      check(acq_v, 1'b1, "acq valid");
      check(acq_d, 16'h1357, "acq data");
      pdap = 1'b0;
      xen = 1'b0;
      en = 1'b1;
    end
  endtask

  task t_gflags;
    begin
      tick(5);
      check({f_oe_n, fcond}, 8'hfd, "flag in");
      fdir = 4'hf;
      fval = 4'h6;
      tick(5);
      check({f_oe_n, f_out}, 8'h06, "flag out");
      fdir = 4'h0;
      system_control_reg = 32'h00070000;
      tick(5);
      check(irq, 3'h5, "irq");
      system_control_reg = 32'h00080000;
      tmr = 1'b1;
      tick(5);
      check({f_oe_n[3], f_out[3]}, 2'h1, "timer out");
      system_control_reg = 32'h0;
      spim = 1'b1;
      sel_en = 4'h2;
      tick(5);
      check({f_oe_n[1], f_out[1]}, 2'h0, "spi sel");
      boot = 1'b1;
      tick(5);
      check(f_oe_n[0], 1'b0, "boot sel");
    end
  endtask

  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask

  initial
  begin
    // a real falling edge, so the async reset acts before the first clock
    #1 nrst = 1'b0;
    tick(3);
    t_reset;
    nrst = 1'b1;
    tick(2);
    t_reset;
    t_bus16;
    t_bus8;
    t_pol;
    t_flags;
    t_gflags;
    report_and_stop;
  end

  // the whole sequence needs well under a thousand cycles
  initial
  begin
    #20000;
    n_fail = n_fail + 1;
    report_and_stop;
  end
endmodule

// >>> verif/pport_mem_model.sv
`timescale 1ns/1ps
module pport_mem_model
(
  // processor pins
  input  wire        i_sys_clk,
  input  wire [15:0] i_ad_out,
  input  wire [15:0] i_ad_oe_n,
  input  wire        i_rd_n,
  input  wire        i_wr_n,
  input  wire        i_ale_on,
  // extra source for input modes
  input  wire        i_ext_en,
  input  wire [15:0] i_ext_val,
  // resolved pins and latch
  output wire [15:0] o_ad_wire,
  output reg  [15:0] o_latch
);
  reg  [15:0] mem [0:15];
  // released lines float up through the pin pull-ups
  wire [15:0] far = i_ext_en ? i_ext_val :
                    (!i_rd_n ? mem[o_latch[3:0]] : 16'hffff);
  assign o_ad_wire = (~i_ad_oe_n & i_ad_out) | (i_ad_oe_n & far);
  always @(posedge i_sys_clk)
  begin
    if (i_ale_on)
      o_latch <= o_ad_wire;
    if (!i_wr_n)
      mem[o_latch[3:0]] <= o_ad_wire;
  end
endmodule
